// >>> common/gpc_pkg.sv
// gpc_pkg: constants, carrier types and register map of the pad configuration block
// assumes one 50 MHz clock and a plain strobe register port with 12-bit byte addresses
//
// Notes on behaviour
// - alt bit 0 software line, 1 hardware
// - alt resets zero; debug pins default hardware
// - 4/8 mA write-one clears 2 mA
// - 2/8 mA write-one clears 4 mA
// - 2/4 mA write-one clears 8 mA
// - sibling clear lands second cycle after write
// - open-drain bit puts pad open drain
// - open drain: direction picks input or output
// - pull-up bit; writing one clears pull-down
// - pull-down bit; writing one clears pull-up
// - slew limit acts only with 8 mA
// - every line digital input after reset
// - input enable gates digital input path
// - any reset restores all defaults
package gpc_pkg;
   localparam int unsigned LINE_CNT = 8;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned SYNC_STAGES = 2;

   // register byte offsets
   localparam logic [11:0] ALT_SEL_OFS = 12'h420;
   localparam logic [11:0] LOW_DRIVE_BITS_OFS = 12'h500;
   localparam logic [11:0] MID_DRIVE_BITS_OFS = 12'h504;
   localparam logic [11:0] HIGH_DRIVE_BITS_OFS = 12'h508;
   localparam logic [11:0] OPEN_DRAIN_OFS = 12'h50c;
   localparam logic [11:0] PULL_UP_OFS = 12'h510;
   localparam logic [11:0] PULL_DOWN_OFS = 12'h514;
   localparam logic [11:0] SLEW_OFS = 12'h518;
   localparam logic [11:0] INPUT_EN_OFS = 12'h51c;

   // reset values
   localparam logic [7:0] ALT_RST_PLAIN = 8'h00;
   localparam logic [7:0] ALT_RST_PORT_B = 8'h80;
   localparam logic [7:0] ALT_RST_PORT_C = 8'h0f;
   localparam logic [7:0] LOW_DRIVE_BITS_RST = 8'hff;
   localparam logic [7:0] MID_DRIVE_BITS_RST = 8'h00;
   localparam logic [7:0] HIGH_DRIVE_BITS_RST = 8'h00;
   localparam logic [7:0] OPEN_DRAIN_RST = 8'h00;
   localparam logic [7:0] PULL_UP_RST = 8'hff;
   localparam logic [7:0] PULL_DOWN_RST = 8'h00;
   localparam logic [7:0] SLEW_RST = 8'h00;
   localparam logic [7:0] INPUT_EN_RST = 8'hff;

   // per-line pad configuration as driven to the pads
   typedef struct packed {
      logic [7:0] altSelectBits;
      logic [7:0] lowDriveBits;
      logic [7:0] midDriveBits;
      logic [7:0] highDriveBits;
      logic [7:0] openDrainBits;
      logic [7:0] pullUpBits;
      logic [7:0] pullDownBits;
      logic [7:0] slewLimitBits;
      logic [7:0] inputEnableBits;
   } gpc_pad_cfg_t;

   // data and enable toward one group of pads
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] oe;
   } gpc_pad_drv_t;
endpackage

// >>> logic/gpc_pad_mux.sv
// gpc_pad_mux: per-line source selection, open-drain shaping and input synchroniser
// assumes software and alternate sources are on core_clk; padIn comes from the pins
`timescale 1ns/1ps
module gpc_pad_mux (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [7:0] altSelectBits,
   input wire logic [7:0] openDrainBits,
   input wire logic [7:0] inputEnableBits,
   input wire gpc_pkg::gpc_pad_drv_t swDrv,
   input wire gpc_pkg::gpc_pad_drv_t altDrv,
   input wire logic [7:0] padIn,
   output gpc_pkg::gpc_pad_drv_t padDrv,
   output logic [7:0] digIn
);
   import gpc_pkg::*;

   logic [7:0] syncA_ff;
   logic [7:0] syncB_ff;
   // per-bit drivers from the generate loop, so nets rather than variables
   wire [7:0] nxt_padData;
   wire [7:0] nxt_padOe;
   gpc_pad_drv_t padDrv_ff;
   logic [7:0] digIn_ff;

   // per line: pick owner, then open drain only ever drives low
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_line
         wire lineData;
         wire lineDir;
         assign lineData = altSelectBits[i] ? altDrv.data[i] : swDrv.data[i];
         assign lineDir = altSelectBits[i] ? altDrv.oe[i] : swDrv.oe[i];
         // open drain: dir 0 is input, dir 1 pulls low when data is 0
         assign nxt_padData[i] = openDrainBits[i] ? 1'b0 : lineData;
         assign nxt_padOe[i] = openDrainBits[i] ? (lineDir & ~lineData) : lineDir;
      end
   endgenerate

   // two-stage synchroniser on the pins; first stage feeds only the second
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         syncA_ff <= 8'h00;
         syncB_ff <= 8'h00;
      end else begin
         syncA_ff <= padIn;
         syncB_ff <= syncA_ff;
      end
   end

   // registered pad drive and gated digital input
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         padDrv_ff <= '0;
         digIn_ff <= 8'h00;
      end else begin
         padDrv_ff <= {nxt_padData, nxt_padOe};
         digIn_ff <= syncB_ff & inputEnableBits;
      end
   end

   assign padDrv = padDrv_ff;
   assign digIn = digIn_ff;
endmodule

// >>> logic/gpc_pad_config.sv
// gpc_pad_config: register file and pad control for one 8-line port
// assumes a strobe register port on core_clk; every reset source is merged into arst_n
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module gpc_pad_config #(
   parameter logic [7:0] ALT_RESET = gpc_pkg::ALT_RST_PLAIN,
   parameter int unsigned LINES = gpc_pkg::LINE_CNT
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [gpc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [gpc_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [gpc_pkg::DATA_W-1:0] regRdData,
   input wire gpc_pkg::gpc_pad_drv_t swDrv,
   input wire gpc_pkg::gpc_pad_drv_t altDrv,
   input wire logic [7:0] padIn,
   output gpc_pkg::gpc_pad_drv_t padDrv,
   output logic [7:0] digIn,
   output gpc_pkg::gpc_pad_cfg_t padCfg
);
   import gpc_pkg::*;

   // the map holds exactly one bit per line in the low byte
   generate
      if (LINES != 8) begin : g_bad_lines
         $error("gpc_pad_config supports exactly 8 lines");
      end
   endgenerate

   // stored register bits
   logic [7:0] alt_ff;
   logic [7:0] low_drive_bits_ff;
   logic [7:0] mid_drive_bits_ff;
   logic [7:0] high_drive_bits_ff;
   logic [7:0] od_ff;
   logic [7:0] pu_ff;
   logic [7:0] pd_ff;
   logic [7:0] slew_ff;
   logic [7:0] den_ff;

   // sibling clears waiting one cycle before they land
   logic [7:0] clr2Pend_ff;
   logic [7:0] clr4Pend_ff;
   logic [7:0] clr8Pend_ff;
   logic [7:0] clrPuPend_ff;
   logic [7:0] clrPdPend_ff;

   logic [DATA_W-1:0] rdData_ff;
   gpc_pad_cfg_t padCfg_ff;

   // write decode; only the low byte is stored, the rest is dropped
   wire [7:0] wrBits;
   wire wrAlt;
   wire wrDrv2;
   wire wrDrv4;
   wire wrDrv8;
   wire wrOd;
   wire wrPu;
   wire wrPd;
   wire wrSlew;
   wire wrDen;
   assign wrBits = regWrData[7:0];
   assign wrAlt = regWrStb && (regAddr == ALT_SEL_OFS);
   assign wrDrv2 = regWrStb && (regAddr == LOW_DRIVE_BITS_OFS);
   assign wrDrv4 = regWrStb && (regAddr == MID_DRIVE_BITS_OFS);
   assign wrDrv8 = regWrStb && (regAddr == HIGH_DRIVE_BITS_OFS);
   assign wrOd = regWrStb && (regAddr == OPEN_DRAIN_OFS);
   assign wrPu = regWrStb && (regAddr == PULL_UP_OFS);
   assign wrPd = regWrStb && (regAddr == PULL_DOWN_OFS);
   assign wrSlew = regWrStb && (regAddr == SLEW_OFS);
   assign wrDen = regWrStb && (regAddr == INPUT_EN_OFS);

   // ones written this cycle, per register
   wire [7:0] ones2;
   wire [7:0] ones4;
   wire [7:0] ones8;
   wire [7:0] onesPu;
   wire [7:0] onesPd;
   assign ones2 = wrDrv2 ? wrBits : 8'h00;
   assign ones4 = wrDrv4 ? wrBits : 8'h00;
   assign ones8 = wrDrv8 ? wrBits : 8'h00;
   assign onesPu = wrPu ? wrBits : 8'h00;
   assign onesPd = wrPd ? wrBits : 8'h00;

   // clear masks, registered on the next edge and applied on the edge after
   wire [7:0] nxt_clr2Pend;
   wire [7:0] nxt_clr4Pend;
   wire [7:0] nxt_clr8Pend;
   wire [7:0] nxt_clrPuPend;
   wire [7:0] nxt_clrPdPend;
   assign nxt_clr2Pend = ones4 | ones8;
   assign nxt_clr4Pend = ones2 | ones8;
   assign nxt_clr8Pend = ones2 | ones4;
   assign nxt_clrPuPend = onesPd;
   assign nxt_clrPdPend = onesPu;

   // a write to the register itself wins over a late sibling clear,
   // so a newly set bit is never lost to an older request
   wire [7:0] nxt_low_drive_bits;
   wire [7:0] nxt_mid_drive_bits;
   wire [7:0] nxt_high_drive_bits;
   wire [7:0] nxt_pu;
   wire [7:0] nxt_pd;
   assign nxt_low_drive_bits = wrDrv2 ? wrBits : (low_drive_bits_ff & ~clr2Pend_ff);
   assign nxt_mid_drive_bits = wrDrv4 ? wrBits : (mid_drive_bits_ff & ~clr4Pend_ff);
   assign nxt_high_drive_bits = wrDrv8 ? wrBits : (high_drive_bits_ff & ~clr8Pend_ff);
   assign nxt_pu = wrPu ? wrBits : (pu_ff & ~clrPuPend_ff);
   assign nxt_pd = wrPd ? wrBits : (pd_ff & ~clrPdPend_ff);

   // plain registers with no side effects
   wire [7:0] nxt_alt;
   wire [7:0] nxt_od;
   wire [7:0] nxt_slew;
   wire [7:0] nxt_den;
   assign nxt_alt = wrAlt ? wrBits : alt_ff;
   assign nxt_od = wrOd ? wrBits : od_ff;
   assign nxt_slew = wrSlew ? wrBits : slew_ff;
   assign nxt_den = wrDen ? wrBits : den_ff;

   // read mux; unmapped offsets and bits 31:8 read zero
   wire [7:0] rdBits;
   wire [DATA_W-1:0] nxt_rdData;
   assign rdBits = (regAddr == ALT_SEL_OFS) ? alt_ff :
                   (regAddr == LOW_DRIVE_BITS_OFS) ? low_drive_bits_ff :
                   (regAddr == MID_DRIVE_BITS_OFS) ? mid_drive_bits_ff :
                   (regAddr == HIGH_DRIVE_BITS_OFS) ? high_drive_bits_ff :
                   (regAddr == OPEN_DRAIN_OFS) ? od_ff :
                   (regAddr == PULL_UP_OFS) ? pu_ff :
                   (regAddr == PULL_DOWN_OFS) ? pd_ff :
                   (regAddr == SLEW_OFS) ? slew_ff :
                   (regAddr == INPUT_EN_OFS) ? den_ff : 8'h00;
   assign nxt_rdData = regRdStb ? {24'h000000, rdBits} : '0;

   // slew limiting only reaches the pad on lines at 8 mA
   wire [7:0] slewEff;
   assign slewEff = slew_ff & high_drive_bits_ff;

   // configuration registers; one async reset covers power-on and pin reset
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         alt_ff <= ALT_RESET;
         low_drive_bits_ff <= LOW_DRIVE_BITS_RST;
         mid_drive_bits_ff <= MID_DRIVE_BITS_RST;
         high_drive_bits_ff <= HIGH_DRIVE_BITS_RST;
         od_ff <= OPEN_DRAIN_RST;
         pu_ff <= PULL_UP_RST;
         pd_ff <= PULL_DOWN_RST;
         slew_ff <= SLEW_RST;
         den_ff <= INPUT_EN_RST;
      end else begin
         alt_ff <= nxt_alt;
         low_drive_bits_ff <= nxt_low_drive_bits;
         mid_drive_bits_ff <= nxt_mid_drive_bits;
         high_drive_bits_ff <= nxt_high_drive_bits;
         od_ff <= nxt_od;
         pu_ff <= nxt_pu;
         pd_ff <= nxt_pd;
         slew_ff <= nxt_slew;
         den_ff <= nxt_den;
      end
   end

   // pending sibling clears, one stage deep
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         clr2Pend_ff <= 8'h00;
         clr4Pend_ff <= 8'h00;
         clr8Pend_ff <= 8'h00;
         clrPuPend_ff <= 8'h00;
         clrPdPend_ff <= 8'h00;
      end else begin
         clr2Pend_ff <= nxt_clr2Pend;
         clr4Pend_ff <= nxt_clr4Pend;
         clr8Pend_ff <= nxt_clr8Pend;
         clrPuPend_ff <= nxt_clrPuPend;
         clrPdPend_ff <= nxt_clrPdPend;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdData_ff <= '0;
      end else begin
         rdData_ff <= nxt_rdData;
      end
   end

   // pad configuration follows the registers one cycle later
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         padCfg_ff <= {ALT_RESET, LOW_DRIVE_BITS_RST, MID_DRIVE_BITS_RST, HIGH_DRIVE_BITS_RST, OPEN_DRAIN_RST,
                       PULL_UP_RST, PULL_DOWN_RST, SLEW_RST, INPUT_EN_RST};
      end else begin
         padCfg_ff <= {alt_ff, low_drive_bits_ff, mid_drive_bits_ff, high_drive_bits_ff, od_ff,
                       pu_ff, pd_ff, slewEff, den_ff};
      end
   end

   // line ownership, open drain and input path
   gpc_pad_mux gpc_pad_mux_inst (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .altSelectBits(alt_ff),
      .openDrainBits(od_ff),
      .inputEnableBits(den_ff),
      .swDrv(swDrv),
      .altDrv(altDrv),
      .padIn(padIn),
      .padDrv(padDrv),
      .digIn(digIn)
   );

   assign regRdData = rdData_ff;
   assign padCfg = padCfg_ff;
endmodule

// >>> tb/gpc_pad_config_checker.sv
// gpc_pad_config_checker: port-level timing checks for the pad configuration block
// assumes it is bound to gpc_pad_config and sees only that module's ports
`timescale 1ns/1ps
module gpc_pad_config_checker #(
   parameter logic [7:0] ALT_RESET = 8'h00,
   parameter int unsigned LINES = 8
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [gpc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [gpc_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [gpc_pkg::DATA_W-1:0] regRdData,
   input wire gpc_pkg::gpc_pad_drv_t swDrv,
   input wire gpc_pkg::gpc_pad_drv_t altDrv,
   input wire logic [7:0] padIn,
   input wire gpc_pkg::gpc_pad_drv_t padDrv,
   input wire logic [7:0] digIn,
   input wire gpc_pkg::gpc_pad_cfg_t padCfg
);
   import gpc_pkg::*;
   gpc_pad_drv_t swQ_ff;
   gpc_pad_drv_t altQ_ff;
   wire [7:0] selData;
   wire [7:0] selOe;
   // pad sources as the design sampled them one edge back
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         swQ_ff <= '0;
         altQ_ff <= '0;
      end else begin
         swQ_ff <= swDrv;
         altQ_ff <= altDrv;
      end
   end
   // per-line source picked by the alternate bits
   assign selData = (padCfg.altSelectBits & altQ_ff.data) | (~padCfg.altSelectBits & swQ_ff.data);
   assign selOe = (padCfg.altSelectBits & altQ_ff.oe) | (~padCfg.altSelectBits & swQ_ff.oe);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // padCfg trails the registers by one edge, so a clear landing at the
   // second edge after the write is seen on padCfg at the third
   rd_idle_zero_a: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
      else $error("read data not zero outside answer cycle");
   rsvd_zero_a: assert property (regRdData[31:8] == 24'h0)
      else $error("reserved read bits not zero");
   low_clear_a: assert property (
      (regWrStb && (regAddr == MID_DRIVE_BITS_OFS || regAddr == HIGH_DRIVE_BITS_OFS)) ##1
      !(regWrStb && regAddr == LOW_DRIVE_BITS_OFS) |=> ##1
      (padCfg.lowDriveBits & $past(regWrData[7:0], 3)) == 8'h0)
      else $error("low drive bit not cleared");
   mid_clear_a: assert property (
      (regWrStb && (regAddr == LOW_DRIVE_BITS_OFS || regAddr == HIGH_DRIVE_BITS_OFS)) ##1
      !(regWrStb && regAddr == MID_DRIVE_BITS_OFS) |=> ##1
      (padCfg.midDriveBits & $past(regWrData[7:0], 3)) == 8'h0)
      else $error("mid drive bit not cleared");
   high_clear_a: assert property (
      (regWrStb && (regAddr == LOW_DRIVE_BITS_OFS || regAddr == MID_DRIVE_BITS_OFS)) ##1
      !(regWrStb && regAddr == HIGH_DRIVE_BITS_OFS) |=> ##1
      (padCfg.highDriveBits & $past(regWrData[7:0], 3)) == 8'h0)
      else $error("high drive bit not cleared");
   pd_clear_a: assert property (
      (regWrStb && regAddr == PULL_UP_OFS) ##1 !(regWrStb && regAddr == PULL_DOWN_OFS)
      |=> ##1 (padCfg.pullDownBits & $past(regWrData[7:0], 3)) == 8'h0)
      else $error("pull-down bit not cleared");
   pu_clear_a: assert property (
      (regWrStb && regAddr == PULL_DOWN_OFS) ##1 !(regWrStb && regAddr == PULL_UP_OFS)
      |=> ##1 (padCfg.pullUpBits & $past(regWrData[7:0], 3)) == 8'h0)
      else $error("pull-up bit not cleared");
   slew_gate_a: assert property ((padCfg.slewLimitBits & ~padCfg.highDriveBits) == 8'h0)
      else $error("slew limit without high drive");
   pad_data_a: assert property (
      $past(arst_n) |-> padDrv.data == (selData & ~padCfg.openDrainBits))
      else $error("pad data wrong");
   pad_oe_a: assert property ($past(arst_n) |-> padDrv.oe ==
      ((padCfg.openDrainBits & selOe & ~selData) | (~padCfg.openDrainBits & selOe)))
      else $error("pad enable wrong");
   dig_in_a: assert property ($past(arst_n) && $past(arst_n, 2) && $past(arst_n, 3)
      |-> digIn == ($past(padIn, 3) & padCfg.inputEnableBits))
      else $error("digital input path wrong");
endmodule

// >>> tb/gpc_pad_config_tb.sv
// gpc_pad_config_tb: directed register and pad tests, port B reset flavour
// assumes package, design and checker are compiled before this file
`timescale 1ns/1ps
module gpc_pad_config_tb;
   import gpc_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [31:0] regWrData = 32'h0;
   logic regWrStb = 1'b0;
   logic regRdStb = 1'b0;
   logic [31:0] regRdData;
   gpc_pad_drv_t swDrv = '0;
   gpc_pad_drv_t altDrv = '0;
   gpc_pad_drv_t padDrv;
   logic [7:0] padIn = 8'h5a;
   logic [7:0] digIn;
   gpc_pad_cfg_t padCfg;
   logic [7:0] expD;
   logic [7:0] expOe;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   // 50 MHz clock
   always #10 core_clk = ~core_clk;
   gpc_pad_config #(.ALT_RESET(8'h80)) gpc_pad_config_inst (
      .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .swDrv(swDrv),
      .altDrv(altDrv), .padIn(padIn), .padDrv(padDrv), .digIn(digIn), .padCfg(padCfg)
   );
   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWrStb <= 1'b1;
      regRdStb <= 1'b0;
      regAddr <= a;
      regWrData <= d;
   endtask
   // the #1 lets the edge's updates land before anything is sampled
   task automatic idle;
      @(posedge core_clk);
      regWrStb <= 1'b0;
      regRdStb <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      regRdStb <= 1'b1;
      regWrStb <= 1'b0;
      regAddr <= a;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      #1;
      check({40'h0, regRdData}, {40'h0, exp});
   endtask
   task automatic chk_reset;
      logic [11:0] ofs [9];
      logic [7:0] val [9];
      ofs = '{ALT_SEL_OFS, LOW_DRIVE_BITS_OFS, MID_DRIVE_BITS_OFS, HIGH_DRIVE_BITS_OFS, OPEN_DRAIN_OFS, PULL_UP_OFS,
         PULL_DOWN_OFS, SLEW_OFS, INPUT_EN_OFS};
      val = '{8'h80, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff};
      for (int i = 0; i < 9; i++) begin
         rd(ofs[i], {24'h0, val[i]});
      end
      check(padCfg, {8'h80, 8'hff, 24'h0, 8'hff, 16'h0, 8'hff});
      check(72'(digIn), 72'h5a);
   endtask
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // hang guard, well above the length of the sequence
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 1000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      chk_reset();
      wr(INPUT_EN_OFS, 32'h0000_000f);
      repeat (4) idle();
      check(72'(digIn), 72'h0a);
      done("reset");
      wr(HIGH_DRIVE_BITS_OFS, 32'h0f);
      rd(LOW_DRIVE_BITS_OFS, 32'hff);
      rd(LOW_DRIVE_BITS_OFS, 32'hf0);
      wr(MID_DRIVE_BITS_OFS, 32'h03);
      idle();
      rd(HIGH_DRIVE_BITS_OFS, 32'h0c);
      wr(LOW_DRIVE_BITS_OFS, 32'h05);
      idle();
      rd(MID_DRIVE_BITS_OFS, 32'h02);
      rd(HIGH_DRIVE_BITS_OFS, 32'h08);
      wr(SLEW_OFS, 32'hff);
      repeat (2) idle();
      check(72'(padCfg.slewLimitBits), 72'h08);
      rd(SLEW_OFS, 32'hff);
      done("drive");
      wr(PULL_DOWN_OFS, 32'h3c);
      rd(PULL_UP_OFS, 32'hff);
      rd(PULL_UP_OFS, 32'hc3);
      wr(PULL_UP_OFS, 32'h0c);
      idle();
      rd(PULL_DOWN_OFS, 32'h30);
      done("pull");
      wr(OPEN_DRAIN_OFS, 32'h0000_0005);
      rd(OPEN_DRAIN_OFS, 32'h05);
      wr(12'h524, 32'hff);
      rd(12'h524, 32'h0);
      done("reserved");
      wr(ALT_SEL_OFS, 32'hcf);
      swDrv <= '{data: 8'h0f, oe: 8'h33};
      altDrv <= '{data: 8'hf0, oe: 8'hcc};
      wr(INPUT_EN_OFS, 32'hff);
      wr(OPEN_DRAIN_OFS, 32'h55);
      repeat (3) idle();
      expD = (8'hcf & 8'hf0) | (~8'hcf & 8'h0f);
      expOe = (8'hcf & 8'hcc) | (~8'hcf & 8'h33);
      check(72'(padDrv.data), 72'(expD & ~8'h55));
      check(72'(padDrv.oe), 72'((8'h55 & expOe & ~expD) | (~8'h55 & expOe)));
      done("pads");
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) idle();
      @(posedge core_clk);
      arst_n <= 1'b1;
      chk_reset();
      done("second reset");
      close_out();
   end
endmodule
bind gpc_pad_config gpc_pad_config_checker #(.ALT_RESET(ALT_RESET), .LINES(LINES))
   gpc_pad_config_checker_inst (
   .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
   .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .swDrv(swDrv),
   .altDrv(altDrv), .padIn(padIn), .padDrv(padDrv), .digIn(digIn), .padCfg(padCfg)
);
